// ===== shared/oer_pkg.sv
/*
 * constants for the octal edge register with three-state outputs.
 * assumes all pins are already synchronous to mclk.
 */
package oer_pkg;
    // number of storage bits and output pins
    localparam int OER_NUM_BITS       = 8;
    // supply level below which outputs float, in millivolts
    localparam int OER_SUPPLY_MIN_MV  = 1500;
    // cycles from a sampled clock-pin rise to the new stored value
    localparam int OER_CAPTURE_CYCLES = 1;
    // reset values of the control flops
    localparam logic OER_PREV_CLK_RST = 1'b0;
    localparam logic OER_LOADED_RST   = 1'b0;
    localparam logic OER_PREV_OK_RST  = 1'b0;

    typedef enum logic {
        OER_EMPTY,
        OER_LOADED
    } oer_fill_t;
endpackage

// ===== shared/oer_hold_if.sv
/*
 * carrier between the top and the input hold module: raw data pins,
 * a per-bit driven flag, and the held level seen by the storage bits.
 * assumes a single clock domain, mclk.
 */
`timescale 1ns/1ps
interface oer_hold_if #(
    parameter int WIDTH = 8
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] driven;
    logic [WIDTH-1:0] level;

    // the hold module turns raw plus driven into a clean level
    modport hold (input raw, input driven, output level);
    // the user supplies pins and reads the level
    modport user (output raw, output driven, input level);
endinterface

// ===== rtl/oer_bus_hold.sv
/*
 * input hold circuit: a bit that nobody drives keeps its last driven
 * level instead of floating.
 * assumes mclk as the only clock; the held level has no reset on purpose.
 */
`timescale 1ns/1ps
module oer_bus_hold
    import oer_pkg::*;
#(
    parameter int WIDTH = OER_NUM_BITS
) (
    input  wire logic mclk,
    oer_hold_if.hold  hif
);
    logic [WIDTH-1:0] kept_reg;

    // remember each bit's last driven level
    always_ff @(posedge mclk) begin
        for (int i = 0; i < WIDTH; i++) begin
            if (hif.driven[i]) begin
                kept_reg[i] <= hif.raw[i];
            end
        end
    end

    // undriven bits show the kept level, driven bits pass straight on
    assign hif.level = (hif.raw & hif.driven) | (kept_reg & ~hif.driven);
endmodule

// ===== rtl/oer_top.sv
/*
 * octal edge-triggered register with three-state outputs, clocked by a
 * sampled clock pin, with output enable, power-up float and input hold.
 * assumes every input is synchronous to mclk; the shared bus outside
 * resolves the pin level from data_out and data_oe.
 */
// How it works
// - eight storage bits sharing clock and enable
// - clock pin rise loads data into storage
// - enable high floats all outputs, low drives
// - enable touches only drivers, never storage
// - low supply floats outputs regardless of enable
// - undriven data inputs keep their last level
`timescale 1ns/1ps
module oer_top
    import oer_pkg::*;
#(
    parameter int WIDTH = OER_NUM_BITS
) (
    input  wire logic             mclk,
    input  wire logic             srst,
    input  wire logic             clk_pin,
    input  wire logic             out_en_n,
    input  wire logic             supply_ok,
    input  wire logic [WIDTH-1:0] data_in,
    input  wire logic [WIDTH-1:0] data_in_driven,
    output logic      [WIDTH-1:0] data_out,
    output logic      [WIDTH-1:0] data_oe,
    output logic                  data_known
);
    // refuse widths the logic cannot serve, at elaboration
    if (WIDTH < 1) begin : g_width_check
        $error("oer_top: WIDTH must be at least one");
    end

    logic             prev_clk_reg;
    logic             prev_ok_reg;
    logic             clk_rise;
    logic [WIDTH-1:0] store_reg;
    oer_fill_t        fill_reg;
    logic             drive_on;

    oer_hold_if #(.WIDTH(WIDTH)) hif ();

    // data pins go through the hold circuit before storage
    assign hif.raw    = data_in;
    assign hif.driven = data_in_driven;

    oer_bus_hold #(
        .WIDTH (WIDTH)
    ) u_hold (
        .mclk (mclk),
        .hif  (hif)
    );

    // previous clock-pin level; prev_ok blocks a false rise after reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            prev_clk_reg <= OER_PREV_CLK_RST;
            prev_ok_reg  <= OER_PREV_OK_RST;
        end else begin
            prev_clk_reg <= clk_pin;
            prev_ok_reg  <= 1'b1;
        end
    end

    // rising edge of the pin, seen one mclk late at most
    assign clk_rise = prev_ok_reg & clk_pin & ~prev_clk_reg;

    // storage bits: one flop each, no reset, enable not consulted
    // no reset on purpose: a real part powers up with random contents,
    // so the bench must load before trusting data_out
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge mclk) begin
                if (clk_rise) begin
                    store_reg[g] <= hif.level[g];
                end
            end
        end
    endgenerate
    // no else branch: a steady pin leaves each bit untouched

    // load tracking; srst stands in for power-up here
    always_ff @(posedge mclk) begin
        if (srst) begin
            fill_reg <= OER_EMPTY;
        end else begin
            case (fill_reg)
                OER_EMPTY: begin
                    if (clk_rise) begin
                        fill_reg <= OER_LOADED;
                    end
                end
                OER_LOADED: fill_reg <= OER_LOADED;
                default:    fill_reg <= OER_EMPTY;
            endcase
        end
    end

    // drivers: combinational so the float takes effect at once
    assign drive_on   = ~out_en_n & supply_ok;
    assign data_oe    = {WIDTH{drive_on}};
    assign data_out   = store_reg;
    assign data_known = (fill_reg == OER_LOADED);

    // assertions
    // storage holds x until its first load, so checks on data_out
    // that compare with an older value wait for data_known

    property p_capture;
        @(posedge mclk) disable iff (srst)
        clk_rise |=> data_out == $past(hif.level);
    endproperty
    a_capture: assert property (p_capture)
        else $error("stored value differs from level at clock rise");

    property p_steady;
        @(posedge mclk) disable iff (srst)
        (prev_ok_reg && data_known && !clk_rise) ##1 !clk_rise
            |-> $stable(data_out);
    endproperty
    a_steady: assert property (p_steady)
        else $error("stored value changed without a clock rise");

    property p_float;
        @(posedge mclk) disable iff (srst)
        out_en_n |-> data_oe == '0;
    endproperty
    a_float: assert property (p_float)
        else $error("outputs driven while enable is high");

    property p_drive;
        @(posedge mclk) disable iff (srst)
        (!out_en_n && supply_ok) |-> data_oe == '1;
    endproperty
    a_drive: assert property (p_drive)
        else $error("outputs floating while enabled and powered");

    property p_oe_uniform;
        @(posedge mclk) disable iff (srst)
        data_oe == '0 || data_oe == '1;
    endproperty
    a_oe_uniform: assert property (p_oe_uniform)
        else $error("output enables of the bits disagree");

    property p_capture_floating;
        @(posedge mclk) disable iff (srst)
        (clk_rise && out_en_n) |=> data_out == $past(hif.level)
            && data_known;
    endproperty
    a_capture_floating: assert property (p_capture_floating)
        else $error("capture lost while outputs floated");

    property p_retain_floating;
        @(posedge mclk) disable iff (srst)
        (data_known && out_en_n && !clk_rise)
            |=> data_out == $past(data_out);
    endproperty
    a_retain_floating: assert property (p_retain_floating)
        else $error("stored value lost while outputs floated");

    property p_power_float;
        @(posedge mclk) disable iff (srst)
        !supply_ok |-> data_oe == '0;
    endproperty
    a_power_float: assert property (p_power_float)
        else $error("outputs driven with supply below threshold");

    property p_hold_level;
        @(posedge mclk) disable iff (srst)
        ##1 1'b1 |-> ((hif.level ^ $past(hif.level)) & ~data_in_driven)
            == '0;
    endproperty
    a_hold_level: assert property (p_hold_level)
        else $error("undriven input did not keep its level");

    property p_driven_pass;
        @(posedge mclk) disable iff (srst)
        ((hif.level ^ data_in) & data_in_driven) == '0;
    endproperty
    a_driven_pass: assert property (p_driven_pass)
        else $error("driven input not passed to storage");

    property p_unknown_until_load;
        @(posedge mclk) disable iff (srst)
        (!data_known && !clk_rise) |=> !data_known;
    endproperty
    a_unknown_until_load: assert property (p_unknown_until_load)
        else $error("contents marked known without a load");

    property p_known_after_load;
        @(posedge mclk) disable iff (srst)
        clk_rise |=> data_known;
    endproperty
    a_known_after_load: assert property (p_known_after_load)
        else $error("contents not marked known after a load");

    property p_known_stays;
        @(posedge mclk) disable iff (srst)
        data_known |=> data_known;
    endproperty
    a_known_stays: assert property (p_known_stays)
        else $error("loaded flag dropped without a reset");

    property p_rise_spacing;
        @(posedge mclk) disable iff (srst)
        clk_rise |=> !clk_rise;
    endproperty
    a_rise_spacing: assert property (p_rise_spacing)
        else $error("two clock rises in consecutive cycles");

    // main scenarios
    c_load_driven: cover property (@(posedge mclk) disable iff (srst)
        clk_rise && !out_en_n ##1 data_oe == '1);
    c_load_floating: cover property (@(posedge mclk) disable iff (srst)
        clk_rise && out_en_n ##2 !out_en_n && supply_ok);
    c_hold_used: cover property (@(posedge mclk) disable iff (srst)
        clk_rise && data_in_driven != '1);
    c_power_float: cover property (@(posedge mclk) disable iff (srst)
        !supply_ok && !out_en_n);
endmodule

// ===== dv/oer_bus_model.sv
/*
 * shared bus model at the register outputs.
 * assumes the register is the only driver on its eight lines.
 */
`timescale 1ns/1ps
module oer_bus_model
    import oer_pkg::*;
(
    input  wire logic                    mclk,
    input  wire logic [OER_NUM_BITS-1:0] data_out,
    input  wire logic [OER_NUM_BITS-1:0] data_oe,
    output logic      [OER_NUM_BITS-1:0] bus_level
);
    logic [OER_NUM_BITS-1:0] last_reg;

    // remember each line's last driven level
    always_ff @(posedge mclk) begin
        for (int i = 0; i < OER_NUM_BITS; i++) begin
            if (data_oe[i]) begin
                last_reg[i] <= data_out[i];
            end
        end
    end

    // released lines show the inverse of the last driven level, so a
    // stale level never looks driven
    always_comb begin
        for (int i = 0; i < OER_NUM_BITS; i++) begin
            bus_level[i] = data_oe[i] ? data_out[i] : ~last_reg[i];
        end
    end
endmodule

// ===== dv/oer_top_bench.sv
/*
 * self-checking bench for the octal edge register.
 * assumes the bus model beside it; inputs change on falling mclk.
 */
`timescale 1ns/1ps
module oer_top_bench;
    import oer_pkg::*;

    typedef struct packed {
        logic       oen;
        logic       sup;
        logic [7:0] din;
        logic [7:0] drv;
        logic [7:0] q;
        logic [7:0] oe;
    } oer_row_t;

    // rows run in order: held bits depend on the row before
    oer_row_t rows [6] = '{
        '{1'b0, 1'b1, 8'ha5, 8'hff, 8'ha5, 8'hff},
        '{1'b1, 1'b1, 8'h3c, 8'hff, 8'h3c, 8'h00},
        '{1'b0, 1'b1, 8'hff, 8'h0f, 8'h3f, 8'hff},
        '{1'b0, 1'b0, 8'h00, 8'hff, 8'h00, 8'h00},
        '{1'b0, 1'b1, 8'h5a, 8'h00, 8'h00, 8'hff},
        '{1'b0, 1'b1, 8'hc3, 8'hff, 8'hc3, 8'hff}};

    logic       mclk = 1'b0;
    logic       srst = 1'b1;
    logic       clk_pin = 1'b1;
    logic       out_en_n = 1'b0;
    logic       supply_ok = 1'b1;
    logic [7:0] data_in = 8'h00;
    logic [7:0] data_in_driven = 8'hff;
    logic [7:0] data_out;
    logic [7:0] data_oe;
    logic       data_known;
    logic [7:0] bus_level;
    int         num_errors = 0;
    int         checks = 0;

    // 100 MHz
    always #5 mclk = ~mclk;

    oer_top u_dut (.mclk(mclk), .srst(srst), .clk_pin(clk_pin),
        .out_en_n(out_en_n), .supply_ok(supply_ok), .data_in(data_in),
        .data_in_driven(data_in_driven), .data_out(data_out),
        .data_oe(data_oe), .data_known(data_known));

    oer_bus_model u_bus (.mclk(mclk), .data_out(data_out),
        .data_oe(data_oe), .bus_level(bus_level));

    task automatic cmp8(input string name, input logic [7:0] exp,
                        input logic [7:0] seen);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cmp1(input string name, input logic exp,
                        input logic seen);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %b seen %b", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // watchdog so a stuck run still reaches the verdict
    initial begin
        repeat (2000) @(posedge mclk);
        num_errors++;
        $display("ERROR timeout expected end seen none");
        end_of_test();
    end

    initial begin
        // clock pin high through reset: release must not look like a rise
        repeat (5) @(negedge mclk);
        cmp1("known_in_reset", 1'b0, data_known);
        cmp8("oe_in_reset", 8'hff, data_oe);
        srst = 1'b0;
        repeat (3) @(negedge mclk);
        cmp1("known_no_rise", 1'b0, data_known);
        foreach (rows[i]) begin
            out_en_n = rows[i].oen;
            supply_ok = rows[i].sup;
            data_in = rows[i].din;
            data_in_driven = rows[i].drv;
            clk_pin = 1'b0;
            @(negedge mclk);
            clk_pin = 1'b1;
            @(negedge mclk);
            cmp8("stored", rows[i].q, data_out);
            cmp8("enable", rows[i].oe, data_oe);
            if (rows[i].oe === 8'hff)
                cmp8("bus", rows[i].q, bus_level);
        end
        cmp1("known_loaded", 1'b1, data_known);
        // steady high then steady low clock pin: data changes ignored
        data_in = 8'h18;
        repeat (4) @(negedge mclk);
        cmp8("steady_high", 8'hc3, data_out);
        clk_pin = 1'b0;
        data_in = 8'h81;
        repeat (4) @(negedge mclk);
        cmp8("steady_low", 8'hc3, data_out);
        // second reset mid-run clears the loaded flag and the pin history, not storage
        srst = 1'b1;
        @(negedge mclk);
        cmp1("known_rst", 1'b0, data_known);
        cmp8("kept_rst", 8'hc3, data_out);
        // pin rising at release must not load: no history yet
        srst = 1'b0;
        clk_pin = 1'b1;
        data_in = 8'h7e;
        repeat (2) @(negedge mclk);
        cmp1("known_rel2", 1'b0, data_known);
        cmp8("kept_rel2", 8'hc3, data_out);
        clk_pin = 1'b0;
        @(negedge mclk);
        clk_pin = 1'b1;
        @(negedge mclk);
        cmp8("load_rel2", 8'h7e, data_out);
        cmp1("known_rel2_load", 1'b1, data_known);
        end_of_test();
    end
endmodule
